// *** hdl/fwg_pkg.sv ***
package fwg_pkg;

   // ------------------------------------------------------------
   // Array geometry
   // ------------------------------------------------------------
   localparam int              ADDR_W      = 21;
   localparam logic [20:0]     ARRAY_MAX   = 21'h1FFFFF;
   localparam logic [20:0]     PAGE_MASK   = 21'h0000FF;
   localparam logic [20:0]     SECT_MASK   = 21'h000FFF;
   localparam logic [20:0]     BLK32_MASK  = 21'h007FFF;
   localparam logic [20:0]     BLK64_MASK  = 21'h00FFFF;
   localparam logic [4:0]      SECT_SHIFT  = 5'h0C;
   localparam logic [4:0]      BLK_SHIFT   = 5'h10;
   localparam logic [2:0]      SECT_LVL_CAP = 3'h4;
   localparam logic [15:0]     PAGE_BYTES  = 16'h0100;
   localparam logic [7:0]      ERASED_BYTE = 8'hFF;

   // ------------------------------------------------------------
   // Opcodes
   // ------------------------------------------------------------
   localparam logic [7:0] OPC_WRITE_ENABLE  = 8'h06;
   localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OPC_STATUS_WRITE  = 8'h01;
   localparam logic [7:0] OPC_PAGE_PROGRAM  = 8'h02;
   localparam logic [7:0] OPC_SECTOR_ERASE  = 8'h20;
   localparam logic [7:0] OPC_BLOCK32_ERASE = 8'h52;
   localparam logic [7:0] OPC_BLOCK64_ERASE = 8'hD8;
   localparam logic [7:0] OPC_CHIP_ERASE_A  = 8'hC7;
   localparam logic [7:0] OPC_CHIP_ERASE_B  = 8'h60;
   localparam logic [7:0] OPC_POWER_DOWN    = 8'hB9;
   localparam logic [7:0] OPC_PD_RELEASE    = 8'hAB;

   // ------------------------------------------------------------
   // Internal cycle times (us) and cycle counts at 25 MHz
   // ------------------------------------------------------------
   localparam int CLK_MHZ      = 25;
   localparam int T_W_US       = 5000;
   localparam int T_PP_US      = 400;
   localparam int T_SE_US      = 50000;
   localparam int T_BE32_US    = 150000;
   localparam int T_BE64_US    = 200000;
   localparam int T_CE_US      = 5000000;
   localparam int T_W_CYC      = T_W_US * CLK_MHZ;
   localparam int T_PP_CYC     = T_PP_US * CLK_MHZ;
   localparam int T_SE_CYC     = T_SE_US * CLK_MHZ;
   localparam int T_BE32_CYC   = T_BE32_US * CLK_MHZ;
   localparam int T_BE64_CYC   = T_BE64_US * CLK_MHZ;
   localparam int T_CE_CYC     = T_CE_US * CLK_MHZ;
   localparam int CNT_W        = 27;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {FWG_ACTIVE, FWG_STANDBY, FWG_DEEP_PD} fwg_power_e;
   typedef enum logic [1:0] {FWG_OP_NONE, FWG_OP_STATUS, FWG_OP_PROGRAM, FWG_OP_ERASE} fwg_op_e;

   typedef struct packed {
      logic [7:0]  opcode;
      logic [23:0] addr;
      logic [15:0] data_bytes;
      logic        byte_aligned;
   } fwg_cmd_s;

   typedef struct packed {
      logic complement_protect;
      logic sector_granularity_bit;
      logic top_bottom_select;
      logic protect_level_bit2;
      logic protect_level_bit1;
      logic protect_level_bit0;
   } fwg_prot_s;

   typedef struct packed {
      fwg_op_e     kind;
      logic [20:0] first;
      logic [20:0] last;
      logic [8:0]  count;
   } fwg_op_s;

endpackage

// *** hdl/fwg_prot_map.sv ***
`timescale 1ns/1ps
`default_nettype none
module fwg_prot_map (
   input  wire fwg_pkg::fwg_prot_s i_prot,
   input  wire logic [20:0]        i_first,
   input  wire logic [20:0]        i_last,
   output logic                    o_hit
);
   import fwg_pkg::*;

   logic [2:0]  level;
   logic [4:0]  shift;
   logic [21:0] free_size;
   logic [20:0] lo;
   logic [20:0] hi;

   always_comb begin
      level = {i_prot.protect_level_bit2, i_prot.protect_level_bit1, i_prot.protect_level_bit0};
      // Unprotected slice: 64 kB << (n-1), or 4 kB << (n-1) capped at 32 kB
      if (i_prot.sector_granularity_bit) begin
         shift = (level >= SECT_LVL_CAP) ? (SECT_SHIFT + 5'h03) : (SECT_SHIFT + {2'h0, level} - 5'h01);
      end else begin
         shift = BLK_SHIFT + {2'h0, level} - 5'h01;
      end
      free_size = 22'h000001 << shift;
      lo = i_prot.top_bottom_select ? free_size[20:0] : 21'h000000;
      hi = i_prot.top_bottom_select ? ARRAY_MAX : (ARRAY_MAX - free_size[20:0]);
      if (!i_prot.complement_protect) begin
         o_hit = 1'b0;
      end else if (level == 3'h0) begin
         o_hit = 1'b1;
      end else if (level[2:1] == 2'h3) begin
         o_hit = 1'b0;
      end else begin
         o_hit = !((i_last < lo) || (i_first > hi));
      end
   end
endmodule // fwg_prot_map
`default_nettype wire

// *** hdl/fwg_write_guard.sv ***
// Contract
// - Program or erase touching any protected address is ignored, array untouched.
// - Complement set, level 000: whole 2 MB array protected.
// - Complement, block mode, bottom: levels 1-5 protect lower 31/32 .. 1/2.
// - Complement, block mode, top: levels 1-5 protect upper 31/32 .. 1/2.
// - Complement, sector mode, bottom: all except top 4/8/16/32 kB protected.
// - Complement, sector mode, top: all except bottom 4/8/16/32 kB protected.
// - Page program takes up to 256 bytes in one page, then a program cycle.
// - Programming only clears bits, never sets them.
// - Erase makes every byte of its region FFh.
// - Sector, block and chip erase, each with its own cycle time.
// - Write-in-progress high throughout status write, program and erase cycles.
// - Chip select low means selected and active, except in deep power-down.
// - After deselect stay active until internal cycle ends, then standby.
// - Deep power-down entered by its command, left only by release command.
// - In deep power-down every command but release is ignored.
// - Write enable latch clears when a program, erase or status write ends.
// - Write-type commands ignored unless chip select rises on a byte boundary.
// - During an internal cycle all commands are ignored here.
// - Release from deep power-down uses opcode ABh.
`timescale 1ns/1ps
`default_nettype none
module fwg_write_guard #(
   parameter int STATUS_CYC  = fwg_pkg::T_W_CYC,
   parameter int PROG_CYC    = fwg_pkg::T_PP_CYC,
   parameter int SECT_CYC    = fwg_pkg::T_SE_CYC,
   parameter int BLK32_CYC   = fwg_pkg::T_BE32_CYC,
   parameter int BLK64_CYC   = fwg_pkg::T_BE64_CYC,
   parameter int CHIP_CYC    = fwg_pkg::T_CE_CYC
) (
   input  wire logic                i_clk,
   input  wire logic                i_rst_n,
   input  wire logic                i_cs_n,
   input  wire logic                i_cmd_valid,
   input  wire fwg_pkg::fwg_cmd_s   i_cmd,
   input  wire fwg_pkg::fwg_prot_s  i_prot,
   input  wire logic                i_byte_valid,
   input  wire logic                i_byte_erase,
   input  wire logic [7:0]          i_byte_old,
   input  wire logic [7:0]          i_byte_new,
   output logic                     o_wip,
   output logic                     o_wel,
   output fwg_pkg::fwg_power_e      o_power,
   output logic                     o_op_start,
   output fwg_pkg::fwg_op_s         o_op,
   output logic                     o_cmd_ignored,
   output logic                     o_release_ack,
   output logic                     o_byte_valid,
   output logic [7:0]               o_byte_out
);
   import fwg_pkg::*;
   default clocking cb_chk @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   // ------------------------------------------------------------
   // Command decode and acceptance
   // ------------------------------------------------------------
   fwg_op_e          kind;
   logic [20:0]      mask;
   logic [20:0]      first;
   logic [20:0]      last;
   logic [CNT_W-1:0] dur;
   logic             is_write_enable_cmd;
   logic             is_wrdi;
   logic             is_dp;
   logic             is_rel;
   logic             prot_hit;
   logic [CNT_W-1:0] busy_cnt;

   always_comb begin
      kind    = FWG_OP_NONE;
      mask    = 21'h000000;
      dur     = '0;
      is_write_enable_cmd = 1'b0;
      is_wrdi = 1'b0;
      is_dp   = 1'b0;
      is_rel  = 1'b0;
      case (i_cmd.opcode)
         OPC_WRITE_ENABLE: is_write_enable_cmd = 1'b1;
         OPC_WRITE_DISABLE: is_wrdi = 1'b1;
         OPC_POWER_DOWN: is_dp = 1'b1;
         OPC_PD_RELEASE: is_rel = 1'b1;
         OPC_STATUS_WRITE: begin
            kind = FWG_OP_STATUS;
            dur  = CNT_W'(STATUS_CYC - 1);
         end
         OPC_PAGE_PROGRAM: begin
            kind = FWG_OP_PROGRAM;
            mask = PAGE_MASK;
            dur  = CNT_W'(PROG_CYC - 1);
         end
         OPC_SECTOR_ERASE: begin
            kind = FWG_OP_ERASE;
            mask = SECT_MASK;
            dur  = CNT_W'(SECT_CYC - 1);
         end
         OPC_BLOCK32_ERASE: begin
            kind = FWG_OP_ERASE;
            mask = BLK32_MASK;
            dur  = CNT_W'(BLK32_CYC - 1);
         end
         OPC_BLOCK64_ERASE: begin
            kind = FWG_OP_ERASE;
            mask = BLK64_MASK;
            dur  = CNT_W'(BLK64_CYC - 1);
         end
         OPC_CHIP_ERASE_A, OPC_CHIP_ERASE_B: begin
            kind = FWG_OP_ERASE;
            mask = ARRAY_MAX;
            dur  = CNT_W'(CHIP_CYC - 1);
         end
         default: kind = FWG_OP_NONE;
      endcase
      first = i_cmd.addr[20:0] & ~mask;
      last  = first | mask;
   end

   fwg_prot_map u_prot_map (
      .i_prot  (i_prot),
      .i_first (first),
      .i_last  (last),
      .o_hit   (prot_hit)
   );
   logic deep;
   logic blocked;
   logic go;
   logic start_op;
   logic write_enable_cmd_ok;
   logic wrdi_ok;
   logic dp_ok;
   logic rel_ok;
   logic decoded;
   logic cycle_done;

   assign deep       = (o_power == FWG_DEEP_PD);
   assign blocked    = o_wip || (deep && !is_rel);
   assign go         = i_cmd_valid && !blocked;
   assign start_op   = go && (kind != FWG_OP_NONE) && i_cmd.byte_aligned && o_wel
                       && !((kind != FWG_OP_STATUS) && prot_hit)
                       && !((kind == FWG_OP_PROGRAM) && (i_cmd.data_bytes == 16'h0000));
   assign write_enable_cmd_ok    = go && is_write_enable_cmd && i_cmd.byte_aligned;
   assign wrdi_ok    = go && is_wrdi && i_cmd.byte_aligned;
   assign dp_ok      = go && is_dp && !deep;
   assign rel_ok     = go && is_rel;
   assign decoded    = (kind != FWG_OP_NONE) || is_write_enable_cmd || is_wrdi || is_dp || is_rel;
   assign cycle_done = o_wip && (busy_cnt == '0);

   // ------------------------------------------------------------
   // Internal cycle timer, write-in-progress, write enable latch
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_wip    <= 1'b0;
         busy_cnt <= '0;
      end else if (start_op) begin
         o_wip    <= 1'b1;
         busy_cnt <= dur;
      end else if (cycle_done) begin
         o_wip    <= 1'b0;
      end else if (o_wip) begin
         busy_cnt <= busy_cnt - CNT_W'(1);
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_wel <= 1'b0;
      end else if (write_enable_cmd_ok) begin
         o_wel <= 1'b1;
      end else if (wrdi_ok || cycle_done) begin
         o_wel <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Power state
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_power <= FWG_STANDBY;
      end else begin
         case (o_power)
            FWG_DEEP_PD: begin
               if (rel_ok) begin
                  o_power <= FWG_ACTIVE;
               end
            end
            default: begin
               if (dp_ok) begin
                  o_power <= FWG_DEEP_PD;
               end else if (!i_cs_n || o_wip || start_op) begin
                  o_power <= FWG_ACTIVE;
               end else begin
                  o_power <= FWG_STANDBY;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Operation launch, command status and byte merge
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_op_start    <= 1'b0;
         o_op          <= '0;
         o_cmd_ignored <= 1'b0;
         o_release_ack <= 1'b0;
      end else begin
         o_op_start    <= start_op;
         o_cmd_ignored <= i_cmd_valid && decoded && !(start_op || write_enable_cmd_ok || wrdi_ok || dp_ok || rel_ok);
         o_release_ack <= rel_ok;
         if (start_op) begin
            o_op.kind  <= kind;
            o_op.first <= first;
            o_op.last  <= last;
            o_op.count <= (i_cmd.data_bytes > PAGE_BYTES) ? 9'h100 : i_cmd.data_bytes[8:0];
         end
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_byte_valid <= 1'b0;
         o_byte_out   <= 8'hFF;
      end else begin
         o_byte_valid <= i_byte_valid;
         if (i_byte_valid) begin
            o_byte_out <= i_byte_erase ? ERASED_BYTE : (i_byte_old & i_byte_new);
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_cycle_end;
      o_wip ##1 !o_wip;
   endsequence
   property p_no_protected_start;
      (o_op_start && o_op.kind != FWG_OP_STATUS) |-> !$past(prot_hit);
   endproperty
   a_no_protected_start: assert property (p_no_protected_start) else $error("protected region launched");
   property p_all_protected;
      (i_cmd_valid && kind == FWG_OP_ERASE && i_prot.complement_protect
       && i_prot[2:0] == 3'h0) |=> !o_op_start && o_cmd_ignored;
   endproperty
   a_all_protected: assert property (p_all_protected) else $error("erase ran with full protection");
   property p_none_protected;
      (i_cmd_valid && kind == FWG_OP_ERASE && o_wel && !o_wip && !deep && i_cmd.byte_aligned
       && i_prot.complement_protect && i_prot[2:1] == 2'h3) |=> o_op_start ##1 o_wip;
   endproperty
   a_none_protected: assert property (p_none_protected) else $error("erase refused with no protection");
   property p_page_count;
      (o_op_start && o_op.kind == FWG_OP_PROGRAM) |-> (o_op.count != 9'h000) && (o_op.count <= 9'h100);
   endproperty
   a_page_count: assert property (p_page_count) else $error("page program count out of range");
   property p_program_clears_only;
      (i_byte_valid && !i_byte_erase) |=> ((o_byte_out & ~$past(i_byte_old)) == 8'h00);
   endproperty
   a_program_clears_only: assert property (p_program_clears_only) else $error("program set a bit");
   property p_erase_ones;
      (i_byte_valid && i_byte_erase) |=> o_byte_valid && (o_byte_out == 8'hFF);
   endproperty
   a_erase_ones: assert property (p_erase_ones) else $error("erased byte not all ones");
   property p_wip_cause;
      $rose(o_wip) |-> o_op_start;
   endproperty
   a_wip_cause: assert property (p_wip_cause) else $error("wip rose without a launch");
   property p_active_selected;
      (!i_cs_n && !deep) |=> (o_power == FWG_ACTIVE);
   endproperty
   a_active_selected: assert property (p_active_selected) else $error("selected but not active");
   property p_active_busy;
      o_wip |-> (o_power == FWG_ACTIVE);
   endproperty
   a_active_busy: assert property (p_active_busy) else $error("left active during a cycle");
   property p_deep_ignores;
      (deep && i_cmd_valid && i_cmd.opcode != OPC_PD_RELEASE) |=> !o_op_start && (o_power == FWG_DEEP_PD);
   endproperty
   a_deep_ignores: assert property (p_deep_ignores) else $error("command honoured in deep power-down");
   property p_wel_clear;
      s_cycle_end |-> !o_wel;
   endproperty
   a_wel_clear: assert property (p_wel_clear) else $error("latch still set after cycle");
   property p_unaligned;
      (i_cmd_valid && !i_cmd.byte_aligned) |=> !o_op_start && !$rose(o_wel);
   endproperty
   a_unaligned: assert property (p_unaligned) else $error("unaligned write command taken");
   property p_busy_ignores;
      (o_wip && i_cmd_valid) |=> !o_op_start && !o_release_ack;
   endproperty
   a_busy_ignores: assert property (p_busy_ignores) else $error("command taken while busy");

endmodule // fwg_write_guard
`default_nettype wire

// *** sim/fwg_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fwg_host_model (
   input  wire logic              i_clk,
   input  wire logic              i_go,
   input  wire fwg_pkg::fwg_cmd_s i_req,
   input  wire logic [3:0]        i_hold,
   output fwg_pkg::fwg_cmd_s      o_cmd,
   output logic                   o_cs_n,
   output logic                   o_cmd_valid,
   output logic                   o_done
);
   import fwg_pkg::*;
   fwg_cmd_s last_cmd;

   initial begin
      o_cs_n = 1'b1;
      o_cmd_valid = 1'b0;
      o_done = 1'b0;
      last_cmd = '0;
      o_cmd = '1;
   end

   // ------------------------------------------------------------
   // One frame: select, clock for i_hold cycles, deselect, report
   // ------------------------------------------------------------
   always begin
      @(posedge i_go);
      @(negedge i_clk);
      o_done = 1'b0;
      o_cs_n = 1'b0;
      repeat (i_hold) @(negedge i_clk);
      o_cs_n = 1'b1;
      @(negedge i_clk);
      o_cmd = i_req;
      last_cmd = i_req;
      o_cmd_valid = 1'b1;
      @(negedge i_clk);
      o_cmd_valid = 1'b0;
      // Released bus never shows the stale command
      o_cmd = ~last_cmd;
      o_done = 1'b1;
   end
endmodule // fwg_host_model
`default_nettype wire

// *** sim/fwg_write_guard_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module fwg_write_guard_tb;
   import fwg_pkg::*;
   localparam int ST_C = 12, PG_C = 24, SE_C = 10, B32_C = 11, B64_C = 13, CE_C = 15;
   localparam logic [7:0]  ERA_OP [5] = '{OPC_SECTOR_ERASE, OPC_BLOCK32_ERASE, OPC_BLOCK64_ERASE,
                                          OPC_CHIP_ERASE_A, OPC_CHIP_ERASE_B};
   localparam logic [20:0] ERA_F [5] = '{21'h123000, 21'h120000, 21'h120000, 21'h000000, 21'h000000};
   localparam logic [20:0] ERA_L [5] = '{21'h123FFF, 21'h127FFF, 21'h12FFFF, 21'h1FFFFF, 21'h1FFFFF};
   localparam int          ERA_D [5] = '{SE_C, B32_C, B64_C, CE_C, CE_C};
   localparam logic [5:0]  PROT_ROW [8] = '{6'h20, 6'h21, 6'h25, 6'h2B, 6'h31, 6'h35, 6'h3A, 6'h27};
   // Address FFFFFF marks an unused entry
   localparam logic [23:0] BAD [8] = '{24'h1FF000, 24'h1EF000, 24'h0FF000, 24'h040000, 24'h1FE000,
                                       24'h1F7000, 24'h002000, 24'hFFFFFF};
   localparam logic [23:0] GOOD [8] = '{24'hFFFFFF, 24'h1F0000, 24'h100000, 24'h03F000, 24'h1FF000,
                                        24'h1F8000, 24'h001000, 24'h1FF000};
   logic       i_clk, i_rst_n, go, deep, i_byte_valid, i_byte_erase;
   logic       cs_n, cmd_valid, done, write_in_progress, write_enable_latch, op_start, ignored, rel_ack, bv;
   logic       seen_start, seen_ign, seen_rel;
   logic [7:0] i_byte_old, i_byte_new, bout;
   logic [3:0] hold;
   fwg_cmd_s   req, cmd;
   fwg_prot_s  prot;
   fwg_power_e power;
   fwg_op_s    op;
   int         wcnt, n_mismatch, n_checks;

   fwg_host_model fwg_host_model_inst (.i_clk(i_clk), .i_go(go), .i_req(req), .i_hold(hold), .o_cmd(cmd),
      .o_cs_n(cs_n), .o_cmd_valid(cmd_valid), .o_done(done));
   fwg_write_guard #(.STATUS_CYC(ST_C), .PROG_CYC(PG_C), .SECT_CYC(SE_C), .BLK32_CYC(B32_C),
      .BLK64_CYC(B64_C), .CHIP_CYC(CE_C)) fwg_write_guard_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_cs_n(cs_n), .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_prot(prot), .i_byte_valid(i_byte_valid),
      .i_byte_erase(i_byte_erase), .i_byte_old(i_byte_old), .i_byte_new(i_byte_new), .o_wip(write_in_progress),
      .o_wel(write_enable_latch), .o_power(power), .o_op_start(op_start), .o_op(op), .o_cmd_ignored(ignored),
      .o_release_ack(rel_ack), .o_byte_valid(bv), .o_byte_out(bout));

   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end

   // ------------------------------------------------------------
   // Answer pulses and busy length
   // ------------------------------------------------------------
   always @(posedge i_clk) begin
      if (op_start === 1'b1) begin
         seen_start <= 1'b1;
         wcnt <= 1;
      end else if (write_in_progress === 1'b1) begin
         wcnt <= wcnt + 1;
      end
      if (ignored === 1'b1) seen_ign <= 1'b1;
      if (rel_ack === 1'b1) seen_rel <= 1'b1;
   end

   task automatic chk_bit(input string what, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %b seen %b", what, e, g);
      end
   endtask

   task automatic chk_val(input string what, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic bounded(input int k, input int lim);
      if (k >= lim) begin
         n_mismatch++;
         $display("MISMATCH wait expected handshake seen timeout");
         complete_run();
      end
   endtask

   task automatic send(input logic [7:0] opc, input logic [23:0] a, input logic [15:0] nb, input logic al);
      int k;
      @(negedge i_clk);
      seen_start = 1'b0;
      seen_ign = 1'b0;
      seen_rel = 1'b0;
      req = '{opcode: opc, addr: a, data_bytes: nb, byte_aligned: al};
      go = 1'b1;
      for (k = 0; k < 40 && cs_n !== 1'b0; k++) @(posedge i_clk);
      bounded(k, 40);
      @(negedge i_clk);
      if (!deep) chk_val("power selected", FWG_ACTIVE, power);
      for (k = 0; k < 40 && done !== 1'b1; k++) @(posedge i_clk);
      bounded(k, 40);
      @(negedge i_clk);
      go = 1'b0;
      repeat (2) @(negedge i_clk);
   endtask

   // Launch seen (or not, st), then the whole busy period
   task automatic launch(input logic st, input fwg_op_e kd, input logic [20:0] f, input logic [20:0] l,
                         input int dur);
      int k;
      chk_bit("op start", st, seen_start);
      chk_val("op kind", kd, op.kind);
      chk_val("op first", f, op.first);
      chk_val("op last", l, op.last);
      chk_bit("wip busy", 1'b1, write_in_progress);
      chk_val("power busy", FWG_ACTIVE, power);
      for (k = 0; k < 2000 && write_in_progress === 1'b1; k++) @(posedge i_clk);
      bounded(k, 2000);
      @(negedge i_clk);
      chk_val("wip length", dur, wcnt);
      chk_bit("wel cleared", 1'b0, write_enable_latch);
      repeat (2) @(negedge i_clk);
      chk_val("power idle", FWG_STANDBY, power);
   endtask

   task automatic merge(input logic er, input logic [7:0] od, input logic [7:0] nw, input logic [7:0] ex);
      @(negedge i_clk);
      i_byte_valid = 1'b1;
      i_byte_erase = er;
      i_byte_old = od;
      i_byte_new = nw;
      @(negedge i_clk);
      chk_bit("byte valid", 1'b1, bv);
      i_byte_valid = 1'b0;
      i_byte_old = ~od;
      i_byte_new = ~nw;
      repeat (2) @(negedge i_clk);
      chk_val("merged byte", ex, bout);
      chk_bit("byte valid end", 1'b0, bv);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {i_rst_n, go, deep, i_byte_valid, i_byte_erase, i_byte_old, i_byte_new} = '0;
      {seen_start, seen_ign, seen_rel, wcnt, n_mismatch, n_checks} = '0;
      req = '0;
      prot = '0;
      hold = 4'h2;
      repeat (12) @(posedge i_clk);
      @(negedge i_clk);
      i_rst_n = 1'b1;
      send(OPC_PAGE_PROGRAM, 24'h000100, 16'h0010, 1'b1);
      chk_bit("program no wel", 1'b1, seen_ign);
      send(OPC_WRITE_ENABLE, 24'h000000, 16'h0000, 1'b0);
      chk_bit("short frame", 1'b1, seen_ign);
      chk_bit("wel short", 1'b0, write_enable_latch);
      send(OPC_WRITE_ENABLE, 24'h000000, 16'h0000, 1'b1);
      chk_bit("wel set", 1'b1, write_enable_latch);
      send(OPC_PAGE_PROGRAM, 24'h000100, 16'h0000, 1'b1);
      chk_bit("empty program", 1'b1, seen_ign);
      send(OPC_WRITE_DISABLE, 24'h000000, 16'h0000, 1'b1);
      chk_bit("wel dropped", 1'b0, write_enable_latch);
      send(OPC_WRITE_ENABLE, 24'h000000, 16'h0000, 1'b1);
      hold = 4'h8;
      send(OPC_PAGE_PROGRAM, 24'h0123AB, 16'h0200, 1'b1);
      chk_val("program count", 32'h0000_0100, op.count);
      hold = 4'h2;
      send(OPC_WRITE_ENABLE, 24'h000000, 16'h0000, 1'b1);
      chk_bit("busy ignore", 1'b1, seen_ign);
      launch(1'b0, FWG_OP_PROGRAM, 21'h012300, 21'h0123FF, PG_C);
      send(OPC_WRITE_ENABLE, 24'h000000, 16'h0000, 1'b1);
      send(OPC_STATUS_WRITE, 24'h000000, 16'h0000, 1'b1);
      launch(1'b1, FWG_OP_STATUS, 21'h000000, 21'h000000, ST_C);
      for (int i = 0; i < 5; i++) begin
         send(OPC_WRITE_ENABLE, 24'h000000, 16'h0000, 1'b1);
         send(ERA_OP[i], 24'h123456, 16'h0000, 1'b1);
         launch(1'b1, FWG_OP_ERASE, ERA_F[i], ERA_L[i], ERA_D[i]);
      end
      for (int i = 0; i < 8; i++) begin
         prot = fwg_prot_s'(PROT_ROW[i]);
         if (BAD[i] != 24'hFFFFFF) begin
            send(OPC_WRITE_ENABLE, 24'h000000, 16'h0000, 1'b1);
            send(OPC_SECTOR_ERASE, BAD[i], 16'h0000, 1'b1);
            chk_bit("protected erase", 1'b1, seen_ign);
         end
         if (GOOD[i] != 24'hFFFFFF) begin
            send(OPC_WRITE_ENABLE, 24'h000000, 16'h0000, 1'b1);
            send(OPC_SECTOR_ERASE, GOOD[i], 16'h0000, 1'b1);
            launch(1'b1, FWG_OP_ERASE, GOOD[i][20:0], GOOD[i][20:0] | 21'h000FFF, SE_C);
         end
      end
      send(OPC_POWER_DOWN, 24'h000000, 16'h0000, 1'b1);
      chk_val("power deep", FWG_DEEP_PD, power);
      deep = 1'b1;
      send(OPC_WRITE_ENABLE, 24'h000000, 16'h0000, 1'b1);
      chk_bit("deep ignore", 1'b1, seen_ign);
      chk_bit("deep wel", 1'b0, write_enable_latch);
      chk_val("still deep", FWG_DEEP_PD, power);
      send(OPC_PD_RELEASE, 24'h000000, 16'h0000, 1'b1);
      deep = 1'b0;
      chk_bit("release ack", 1'b1, seen_rel);
      chk_val("power woke", FWG_STANDBY, power);
      merge(1'b0, 8'hA5, 8'h3C, 8'h24);
      merge(1'b0, 8'h0F, 8'hF0, 8'h00);
      merge(1'b1, 8'h00, 8'h12, 8'hFF);
      complete_run();
   end
endmodule // fwg_write_guard_tb
`default_nettype wire
